// ---- core/ioj_alu.sv ----
// Result and zero detection for the increment and OR operations.
`timescale 1ns/100ps
module ioj_alu (
	input wire ioj_pkg::ioj_op_t op,
	input wire logic [ioj_pkg::DATA_W-1:0] acc,
	input wire logic [ioj_pkg::DATA_W-1:0] loc,
	input wire logic [ioj_pkg::DATA_W-1:0] imm,
	output logic [ioj_pkg::DATA_W-1:0] result,
	output logic zero
);

	// ==========================================================================
	// Datapath
	always_comb begin
		case (op)
			ioj_pkg::IOJ_INCR_LOCATION,
			ioj_pkg::IOJ_INCR_SKIP_IF_ZERO: begin
				result = ioj_pkg::DATA_W'(loc + ioj_pkg::DATA_ONE); // [RULE2] [RULE3]
			end
			ioj_pkg::IOJ_OR_LITERAL_INTO_ACC: begin
				result = acc | imm; // [RULE8]
			end
			ioj_pkg::IOJ_OR_ACC_WITH_LOCATION: begin
				result = acc | loc; // [RULE9]
			end
			default: begin
				result = acc;
			end
		endcase
	end

	// The carry out of the increment is dropped on purpose, so 8'hFF wraps to zero.
	assign zero = (result == ioj_pkg::DATA_ZERO); // [RULE10]

endmodule

// ---- core/ioj_exec.sv ----
// Execution unit for increment, increment-and-skip, absolute jump and OR operations.
`timescale 1ns/100ps
// Functional notes
// RULE1 - Register operations take a 7-bit address; dest 0 to accumulator, 1 to location.
// RULE2 - Increment adds one to the location, routes by dest, updates zero flag.
// RULE3 - Increment-and-skip keeps flags; a zero result turns next slot into a no-op.
// RULE4 - Nonzero increment-and-skip result lets the next instruction run with no gap.
// RULE5 - Absolute jump loads its 11-bit operand into program counter bits 10 to 0.
// RULE6 - Program counter bits 12 and 11 come from latch bits 4 and 3.
// RULE7 - Absolute jump takes two instruction cycles and leaves all flags alone.
// RULE8 - Literal OR combines accumulator with 8-bit literal into accumulator, updates zero.
// RULE9 - Register OR combines accumulator with location, routes by dest, updates zero.
// RULE10 - Zero flag is set for a zero 8-bit result and cleared otherwise.
// RULE11 - Increment and both ORs take one cycle and advance program counter by one.
module ioj_exec (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire ioj_pkg::ioj_req_t issue,
	output logic [ioj_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic [ioj_pkg::DATA_W-1:0] mem_rd_data,
	output ioj_pkg::ioj_wr_t mem_wr,
	input wire logic [ioj_pkg::LATCH_W-1:0] upper_address_latch,
	output logic [ioj_pkg::DATA_W-1:0] acc,
	output logic zero_flag,
	output logic [ioj_pkg::PC_W-1:0] program_counter
);

	// ==========================================================================
	// Decode
	ioj_pkg::ioj_state_t state;
	ioj_pkg::ioj_state_t next_state;
	logic fire;
	logic is_reg_op;
	logic is_one_cycle;
	logic updates_zero;
	logic skip;
	logic skip_pending;
	logic [ioj_pkg::DATA_W-1:0] alu_result;
	logic alu_zero;

	assign issue_ready = (state == ioj_pkg::IOJ_ST_EXEC);
	assign fire = ce && issue_valid && issue_ready;
	assign mem_rd_addr = issue.addr; // [RULE1]
	assign is_reg_op = (issue.op == ioj_pkg::IOJ_INCR_LOCATION)
		|| (issue.op == ioj_pkg::IOJ_INCR_SKIP_IF_ZERO)
		|| (issue.op == ioj_pkg::IOJ_OR_ACC_WITH_LOCATION);
	assign updates_zero = (issue.op == ioj_pkg::IOJ_INCR_LOCATION)
		|| (issue.op == ioj_pkg::IOJ_OR_LITERAL_INTO_ACC)
		|| (issue.op == ioj_pkg::IOJ_OR_ACC_WITH_LOCATION); // [RULE3] [RULE7]
	assign is_one_cycle = updates_zero;
	assign skip = (issue.op == ioj_pkg::IOJ_INCR_SKIP_IF_ZERO) && alu_zero; // [RULE3]

	ioj_alu u_alu (
		.op(issue.op),
		.acc(acc),
		.loc(mem_rd_data),
		.imm(issue.imm[ioj_pkg::DATA_W-1:0]),
		.result(alu_result),
		.zero(alu_zero)
	);

	// ==========================================================================
	// Sequencing
	always_comb begin
		next_state = state;
		case (state)
			ioj_pkg::IOJ_ST_EXEC: begin
				if (fire && (skip || issue.op == ioj_pkg::IOJ_JUMP_ABSOLUTE)) begin
					next_state = ioj_pkg::IOJ_ST_SECOND; // [RULE3] [RULE7]
				end
			end
			ioj_pkg::IOJ_ST_SECOND: begin
				if (ce) begin
					next_state = ioj_pkg::IOJ_ST_EXEC;
				end
			end
			default: begin
				next_state = ioj_pkg::IOJ_ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ioj_pkg::IOJ_ST_EXEC;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================================
	// Program counter
	// The skipped slot is consumed here as a no-op, so the issuer must not send it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			program_counter <= ioj_pkg::PC_RESET;
		end else if (fire) begin
			if (issue.op == ioj_pkg::IOJ_JUMP_ABSOLUTE) begin
				program_counter <= {upper_address_latch[ioj_pkg::LATCH_HI_BIT:ioj_pkg::LATCH_LO_BIT],
					issue.imm}; // [RULE5] [RULE6]
			end else begin
				program_counter <= program_counter + ioj_pkg::PC_STEP; // [RULE11] [RULE4]
			end
		end else if (ce && state == ioj_pkg::IOJ_ST_SECOND) begin
			if (skip_pending) begin
				program_counter <= program_counter + ioj_pkg::PC_STEP; // [RULE3]
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			skip_pending <= 1'b0;
		end else if (fire) begin
			skip_pending <= skip;
		end
	end

	// ==========================================================================
	// Accumulator and zero flag
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc <= ioj_pkg::ACC_RESET;
		end else if (fire && issue.op != ioj_pkg::IOJ_JUMP_ABSOLUTE && issue.op != ioj_pkg::IOJ_NOP) begin
			if (!is_reg_op || issue.dest == ioj_pkg::DEST_ACC) begin
				acc <= alu_result; // [RULE1] [RULE8]
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			zero_flag <= 1'b0;
		end else if (fire && updates_zero) begin
			zero_flag <= alu_zero; // [RULE10]
		end
	end

	// ==========================================================================
	// Data memory write-back
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_wr <= '0;
		end else if (ce) begin
			mem_wr.wr <= fire && is_reg_op && issue.dest == ioj_pkg::DEST_LOC; // [RULE1]
			mem_wr.addr <= issue.addr;
			mem_wr.data <= alu_result; // [RULE2] [RULE9]
		end
	end

	// ==========================================================================
	// Checks
	property p_dest_loc;
		@(posedge clock) disable iff (rst)
		fire && is_reg_op && issue.dest == ioj_pkg::DEST_LOC
			|=> mem_wr.wr && mem_wr.addr == $past(issue.addr) && $stable(acc);
	endproperty
	a_dest_loc: assert property (p_dest_loc) else $error("location write missing"); // [RULE1]

	property p_incr;
		@(posedge clock) disable iff (rst)
		fire && issue.op == ioj_pkg::IOJ_INCR_LOCATION && issue.dest == ioj_pkg::DEST_ACC
			|=> acc == ioj_pkg::DATA_W'($past(mem_rd_data) + ioj_pkg::DATA_ONE)
			&& zero_flag == ($past(mem_rd_data) == 8'hFF);
	endproperty
	a_incr: assert property (p_incr) else $error("increment result wrong"); // [RULE2]

	property p_skip;
		@(posedge clock) disable iff (rst)
		fire && issue.op == ioj_pkg::IOJ_INCR_SKIP_IF_ZERO && mem_rd_data == 8'hFF
			|=> !issue_ready && $stable(zero_flag);
	endproperty
	a_skip: assert property (p_skip) else $error("zero result did not skip"); // [RULE3]

	property p_no_skip;
		@(posedge clock) disable iff (rst)
		fire && issue.op == ioj_pkg::IOJ_INCR_SKIP_IF_ZERO && mem_rd_data != 8'hFF
			|=> issue_ready && program_counter == $past(program_counter) + ioj_pkg::PC_STEP;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("nonzero result skipped"); // [RULE4]

	property p_jump_target;
		@(posedge clock) disable iff (rst)
		fire && issue.op == ioj_pkg::IOJ_JUMP_ABSOLUTE
			|=> program_counter[10:0] == $past(issue.imm)
			&& program_counter[12:11] == $past(upper_address_latch[4:3]);
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("jump target wrong"); // [RULE5]

	property p_jump_cycles;
		@(posedge clock) disable iff (rst)
		fire && issue.op == ioj_pkg::IOJ_JUMP_ABSOLUTE
			|=> !issue_ready && $stable(zero_flag) ##1 $stable(program_counter) && $stable(zero_flag);
	endproperty
	a_jump_cycles: assert property (p_jump_cycles) else $error("jump not two cycles"); // [RULE7]

	property p_or_lit;
		@(posedge clock) disable iff (rst)
		fire && issue.op == ioj_pkg::IOJ_OR_LITERAL_INTO_ACC
			|=> acc == ($past(acc) | $past(issue.imm[7:0])) && zero_flag == (acc == 8'h00);
	endproperty
	a_or_lit: assert property (p_or_lit) else $error("literal OR wrong"); // [RULE8]

	property p_or_loc;
		@(posedge clock) disable iff (rst)
		fire && issue.op == ioj_pkg::IOJ_OR_ACC_WITH_LOCATION && issue.dest == ioj_pkg::DEST_LOC
			|=> mem_wr.data == ($past(acc) | $past(mem_rd_data));
	endproperty
	a_or_loc: assert property (p_or_loc) else $error("register OR wrong"); // [RULE9]

	property p_one_cycle;
		@(posedge clock) disable iff (rst)
		fire && is_one_cycle
			|=> issue_ready && program_counter == $past(program_counter) + ioj_pkg::PC_STEP;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("single-cycle op stalled"); // [RULE11]

endmodule

// ---- core/ioj_pkg.sv ----
// Shared constants and types for the increment, jump and OR execution block.
package ioj_pkg;

	// ==========================================================================
	// Widths and field positions
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int JUMP_W = 11;
	localparam int PC_W = 13;
	localparam int LATCH_W = 8;
	localparam int LATCH_HI_BIT = 4;
	localparam int LATCH_LO_BIT = 3;

	// ==========================================================================
	// Reset values and encodings
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_LOC = 1'b1;

	// ==========================================================================
	// Types
	typedef enum logic [2:0] {
		IOJ_NOP = 3'h0,
		IOJ_INCR_LOCATION = 3'h1,
		IOJ_INCR_SKIP_IF_ZERO = 3'h2,
		IOJ_JUMP_ABSOLUTE = 3'h3,
		IOJ_OR_LITERAL_INTO_ACC = 3'h4,
		IOJ_OR_ACC_WITH_LOCATION = 3'h5
	} ioj_op_t;

	typedef enum logic [1:0] {
		IOJ_ST_EXEC = 2'b01,
		IOJ_ST_SECOND = 2'b10
	} ioj_state_t;

	typedef struct packed {
		ioj_op_t op;
		logic [ADDR_W-1:0] addr;
		logic dest;
		logic [JUMP_W-1:0] imm;
	} ioj_req_t;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ioj_wr_t;

endpackage

// ---- verif/ioj_exec_tb.sv ----
// Self-checking testbench for the increment, jump and OR execution block.
`timescale 1ns/100ps
module ioj_exec_tb;
	// ==========================================================================
	// Stimulus and observed signals
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic issue_valid = 1'b0;
	logic issue_ready;
	ioj_pkg::ioj_req_t issue = '0;
	logic [ioj_pkg::ADDR_W-1:0] mem_rd_addr;
	logic [ioj_pkg::DATA_W-1:0] mem_rd_data = 8'h00;
	ioj_pkg::ioj_wr_t mem_wr;
	logic [ioj_pkg::LATCH_W-1:0] upper_address_latch = 8'h00;
	logic [ioj_pkg::DATA_W-1:0] acc;
	logic zero_flag;
	logic [ioj_pkg::PC_W-1:0] program_counter;
	logic [ioj_pkg::PC_W-1:0] exp_pc = 13'h0000;
	int fails = 0;
	int compares = 0;
	int cycles = 0;

	ioj_exec uut (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.issue_valid(issue_valid),
		.issue_ready(issue_ready),
		.issue(issue),
		.mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data),
		.mem_wr(mem_wr),
		.upper_address_latch(upper_address_latch),
		.acc(acc),
		.zero_flag(zero_flag),
		.program_counter(program_counter)
	);

	always #5 clock = ~clock;

	// ==========================================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		compares++;
		if (seen !== expected) begin
			fails++;
			$display("FAIL t=%0t seen=%h expected=%h", $time, seen, expected);
		end
	endtask

	task automatic conclude();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// A gap cycle follows each op, so the one-cycle write pulse can be seen alone.
	task automatic run_op(input ioj_pkg::ioj_op_t op, input logic [6:0] a, input logic d,
		input logic [10:0] k, input logic [7:0] loc);
		@(negedge clock);
		issue = '{op: op, addr: a, dest: d, imm: k};
		mem_rd_data = loc;
		issue_valid = 1'b1;
		#1;
		check(issue_ready, 1'b1);
		check(mem_rd_addr, a);
		@(negedge clock);
		issue_valid = 1'b0;
		if (op == ioj_pkg::IOJ_JUMP_ABSOLUTE) begin
			exp_pc = {upper_address_latch[4:3], k};
		end else begin
			exp_pc = exp_pc + 13'h0001;
		end
		check(program_counter, exp_pc);
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_or_literal();
		run_op(ioj_pkg::IOJ_OR_LITERAL_INTO_ACC, 7'h00, 1'b0, 11'h000, 8'h00);
		check({acc, 7'h00, zero_flag}, 16'h0001);
		run_op(ioj_pkg::IOJ_OR_LITERAL_INTO_ACC, 7'h00, 1'b0, 11'h781, 8'h00);
		check({acc, 7'h00, zero_flag}, 16'h8100);
	endtask

	task automatic t_incr();
		run_op(ioj_pkg::IOJ_INCR_LOCATION, 7'h7f, 1'b1, 11'h000, 8'hff);
		check(mem_wr, {1'b1, 7'h7f, 8'h00});
		check({acc, 7'h00, zero_flag}, 16'h8101);
		@(negedge clock);
		check(mem_wr.wr, 1'b0);
		run_op(ioj_pkg::IOJ_INCR_LOCATION, 7'h00, 1'b0, 11'h000, 8'h41);
		check({acc, 7'h00, zero_flag}, 16'h4200);
		check(mem_wr.wr, 1'b0);
	endtask

	task automatic t_or_loc();
		run_op(ioj_pkg::IOJ_OR_ACC_WITH_LOCATION, 7'h2a, 1'b1, 11'h000, 8'h14);
		check(mem_wr, {1'b1, 7'h2a, 8'h56});
		check({acc, 7'h00, zero_flag}, 16'h4200);
		run_op(ioj_pkg::IOJ_OR_ACC_WITH_LOCATION, 7'h15, 1'b0, 11'h000, 8'h81);
		check({acc, 7'h00, zero_flag}, 16'hc300);
		run_op(ioj_pkg::IOJ_NOP, 7'h15, 1'b1, 11'h0ff, 8'h00);
		check({acc, 7'h00, zero_flag}, 16'hc300);
		check(mem_wr.wr, 1'b0);
	endtask

	task automatic t_skip();
		run_op(ioj_pkg::IOJ_INCR_SKIP_IF_ZERO, 7'h05, 1'b1, 11'h000, 8'hff);
		check(mem_wr, {1'b1, 7'h05, 8'h00});
		check({issue_ready, zero_flag}, 2'b00);
		@(negedge clock);
		exp_pc = exp_pc + 13'h0001;
		check({issue_ready, program_counter}, {1'b1, exp_pc});
		run_op(ioj_pkg::IOJ_INCR_LOCATION, 7'h05, 1'b1, 11'h000, 8'hff);
		run_op(ioj_pkg::IOJ_INCR_SKIP_IF_ZERO, 7'h06, 1'b0, 11'h000, 8'h7f);
		check({acc, 6'h00, issue_ready, zero_flag}, 16'h8003);
	endtask

	task automatic t_jump();
		upper_address_latch = 8'h10;
		@(negedge clock);
		issue = '{op: ioj_pkg::IOJ_JUMP_ABSOLUTE, addr: 7'h00, dest: 1'b0, imm: 11'h7ff};
		issue_valid = 1'b1;
		@(negedge clock);
		issue = '{op: ioj_pkg::IOJ_OR_LITERAL_INTO_ACC, addr: 7'h00, dest: 1'b0, imm: 11'h001};
		check(program_counter, 13'h17ff);
		check({issue_ready, zero_flag}, 2'b01);
		@(negedge clock);
		check({acc, program_counter}, {8'h80, 13'h17ff});
		check(issue_ready, 1'b1);
		@(negedge clock);
		issue_valid = 1'b0;
		check({acc, program_counter}, {8'h81, 13'h1800});
		upper_address_latch = 8'he7;
		run_op(ioj_pkg::IOJ_JUMP_ABSOLUTE, 7'h00, 1'b0, 11'h2a5, 8'h00);
		check(program_counter, 13'h02a5);
		@(negedge clock);
		exp_pc = 13'h02a5;
	endtask

	task automatic t_hold();
		@(negedge clock);
		ce = 1'b0;
		issue = '{op: ioj_pkg::IOJ_OR_LITERAL_INTO_ACC, addr: 7'h00, dest: 1'b0, imm: 11'h0ff};
		issue_valid = 1'b1;
		repeat (2) @(negedge clock);
		check({acc, program_counter}, {8'h81, exp_pc});
		issue_valid = 1'b0;
		ce = 1'b1;
	endtask

	// ==========================================================================
	// Main sequence and hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(negedge clock);
		check({mem_wr, issue_ready, zero_flag}, 18'h0_0002);
		check({acc, program_counter}, 21'h00_0000);
		rst = 1'b0;
		t_or_literal();
		t_incr();
		t_or_loc();
		t_skip();
		t_jump();
		t_hold();
		conclude();
	end
endmodule
